// ==== shared/gpe_pkg.sv ====
`default_nettype none
package gpe_pkg;

  // ****************************************
  // Geometry of the port block.
  // ****************************************
  localparam int GPE_W      = 32;         // Pins per port, bit n is pin n.
  localparam int GPE_NPORT  = 3;          // Ports 0, 1 and 2.
  localparam int GPE_NEDGE  = 2;          // Ports that carry edge detection.
  localparam int GPE_NEB    = GPE_NEDGE * GPE_W;
  localparam int GPE_EDGE_MAP [GPE_NEDGE] = '{0, 2}; // Edge slot to port.
  localparam int GPE_NLANE  = 4;          // Byte lanes of the bus word.
  localparam int GPE_LANE_W = 8;          // Bits per byte lane.

  // ****************************************
  // Address fields and register offsets.
  // ****************************************
  localparam int GPE_AW      = 12;        // Decoded address width.
  localparam int GPE_IDX_LSB = 5;         // Port or edge slot index field.
  localparam int GPE_IDX_MSB = 6;
  localparam int GPE_RGN_BIT = 7;         // Zero selects ports, one edge slots.
  localparam int GPE_TOP_LSB = 8;         // Bits above must be zero.
  localparam logic [4:0] GPE_OFS_DIR  = 5'h00; // Direction, one is output.
  localparam logic [4:0] GPE_OFS_MASK = 5'h04; // One hides a bit from access.
  localparam logic [4:0] GPE_OFS_PIN  = 5'h08; // Read pins, write output value.
  localparam logic [4:0] GPE_OFS_SET  = 5'h0C; // Write ones to set, read latch.
  localparam logic [4:0] GPE_OFS_CLR  = 5'h10; // Write ones to clear.
  localparam logic [4:0] GPE_OFS_RISE = 5'h00; // Rising edge enables.
  localparam logic [4:0] GPE_OFS_FALL = 5'h04; // Falling edge enables.
  localparam logic [4:0] GPE_OFS_STAT = 5'h08; // Sticky edge status, write one clears.
  localparam logic [4:0] GPE_OFS_IEN  = 5'h0C; // Interrupt mask, one passes.

  // ****************************************
  // Reset values.
  // ****************************************
  localparam logic [GPE_W-1:0]   GPE_ZERO    = 32'h0000_0000;
  localparam logic [GPE_NEB-1:0] GPE_CLR_RST = {GPE_NEB{1'b1}};

  // Register selected by an address.
  typedef enum logic [3:0] {
    GPE_R_NONE = 4'b0000,
    GPE_R_DIR  = 4'b0001,
    GPE_R_MASK = 4'b0010,
    GPE_R_PIN  = 4'b0011,
    GPE_R_SET  = 4'b0100,
    GPE_R_CLR  = 4'b0101,
    GPE_R_RISE = 4'b0110,
    GPE_R_FALL = 4'b0111,
    GPE_R_STAT = 4'b1000,
    GPE_R_IEN  = 4'b1001
  } gpe_reg_t;

  typedef struct packed {
    gpe_reg_t   kind;
    logic [1:0] idx;
  } gpe_dec_t;

  // Address decode shared by the read and the write path.
  function automatic gpe_dec_t gpe_decode(input logic [GPE_AW-1:0] a);
    gpe_dec_t d;
    d.idx  = a[GPE_IDX_MSB:GPE_IDX_LSB];
    d.kind = GPE_R_NONE;
    if (a[GPE_AW-1:GPE_TOP_LSB] == '0) begin
      if (!a[GPE_RGN_BIT] && int'(d.idx) < GPE_NPORT) begin
        case (a[GPE_IDX_LSB-1:0])
          GPE_OFS_DIR:  d.kind = GPE_R_DIR;
          GPE_OFS_MASK: d.kind = GPE_R_MASK;
          GPE_OFS_PIN:  d.kind = GPE_R_PIN;
          GPE_OFS_SET:  d.kind = GPE_R_SET;
          GPE_OFS_CLR:  d.kind = GPE_R_CLR;
          default:      d.kind = GPE_R_NONE;
        endcase
      end else if (a[GPE_RGN_BIT] && int'(d.idx) < GPE_NEDGE) begin
        case (a[GPE_IDX_LSB-1:0])
          GPE_OFS_RISE: d.kind = GPE_R_RISE;
          GPE_OFS_FALL: d.kind = GPE_R_FALL;
          GPE_OFS_STAT: d.kind = GPE_R_STAT;
          GPE_OFS_IEN:  d.kind = GPE_R_IEN;
          default:      d.kind = GPE_R_NONE;
        endcase
      end
    end
    return d;
  endfunction

  // Expands byte strobes into a bit mask.
  function automatic logic [GPE_W-1:0] gpe_lanes(input logic [GPE_NLANE-1:0] s);
    logic [GPE_W-1:0] m;
    m = '0;
    for (int i = 0; i < GPE_NLANE; i++) begin
      m[i*GPE_LANE_W +: GPE_LANE_W] = {GPE_LANE_W{s[i]}};
    end
    return m;
  endfunction

  // Replaces the bits selected by m.
  function automatic logic [GPE_W-1:0] gpe_merge(input logic [GPE_W-1:0] o,
                                                 input logic [GPE_W-1:0] n,
                                                 input logic [GPE_W-1:0] m);
    return (o & ~m) | (n & m);
  endfunction

endpackage
`default_nettype wire

// ==== shared/gpe_edge_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Carries the edge capture path between the register block, the
// clockless capture flops and their synchroniser.
interface gpe_edge_if #(parameter int N = 64) ();
  logic [N-1:0] pins;    // Raw pin levels, also used as capture clocks.
  logic [N-1:0] rise_en; // Rising edge enables.
  logic [N-1:0] fall_en; // Falling edge enables.
  logic [N-1:0] capt;    // Captured edge, held until cleared.
  logic [N-1:0] clr;     // Clears the capture flops.
  logic [N-1:0] evt;     // One-cycle event in the system clock domain.
  modport ctl (output pins, rise_en, fall_en, input capt, evt);
  modport cap (input pins, rise_en, fall_en, clr, output capt);
  modport syn (input capt, output clr, evt);
endinterface
`default_nettype wire

// ==== rtl/gpe_edge_cap.sv ====
`timescale 1ns/10ps
`default_nettype none
// Each pin clocks its own pair of capture flops, so an edge is held even
// while the system clock is stopped.
module gpe_edge_cap
  import gpe_pkg::*;
(
  gpe_edge_if.cap e
);

  // ****************************************
  // Per-pin capture.
  // ****************************************
  for (genvar i = 0; i < GPE_NEB; i++) begin : g_bit
    logic rq;      // Rising edge seen.
    logic fq;      // Falling edge seen.
    logic next_rq;
    logic next_fq;

    // An enabled edge sets the flop; a disabled one leaves it alone.
    always_comb begin
      next_rq = rq | e.rise_en[i];
      next_fq = fq | e.fall_en[i];
    end

    // Clear is asynchronous; edges arriving while it is high are lost.
    always_ff @(posedge e.pins[i] or posedge e.clr[i]) begin
      if (e.clr[i]) begin
        rq <= 1'b0;
      end else begin
        rq <= next_rq;
      end
    end

    always_ff @(negedge e.pins[i] or posedge e.clr[i]) begin
      if (e.clr[i]) begin
        fq <= 1'b0;
      end else begin
        fq <= next_fq;
      end
    end

    assign e.capt[i] = rq | fq;
  end

endmodule
`default_nettype wire

// ==== rtl/gpe_edge_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// Brings captured edges into the system clock domain as one-cycle events
// and hands back the clear that rearms the capture flops.
module gpe_edge_sync
  import gpe_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  gpe_edge_if.syn   e
);

  logic [GPE_NEB-1:0] s1;      // First stage, read only by s2.
  logic [GPE_NEB-1:0] s2;      // Safe copy of the capture.
  logic [GPE_NEB-1:0] s3;      // Previous s2, for the rising detect.
  logic [GPE_NEB-1:0] clrq;    // Clear back to the capture flops.
  logic [GPE_NEB-1:0] next_s1;
  logic [GPE_NEB-1:0] next_s2;
  logic [GPE_NEB-1:0] next_s3;
  logic [GPE_NEB-1:0] next_clrq;

  // Clear follows the synchronised copy, so it falls only once the
  // capture has really gone low: a full four-phase handshake.
  always_comb begin
    next_s1   = e.capt;
    next_s2   = s1;
    next_s3   = s2;
    next_clrq = s2;
  end

  // Clear is held high in reset so stale captures are discarded.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      clrq <= GPE_CLR_RST;
    end else begin
      s1   <= next_s1;
      s2   <= next_s2;
      s3   <= next_s3;
      clrq <= next_clrq;
    end
  end

  assign e.clr = clrq;
  assign e.evt = s2 & ~s3;

endmodule
`default_nettype wire

// ==== rtl/gpe_port.sv ====
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module gpe_port
  import gpe_pkg::*;
(
  input  wire logic                             clk_sys,
  input  wire logic                             rst,
  input  wire logic [GPE_AW-1:0]                paddr,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [GPE_W-1:0]                 pwdata,
  input  wire logic [GPE_NLANE-1:0]             pstrb,
  output logic      [GPE_W-1:0]                 prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [GPE_NPORT-1:0][GPE_W-1:0]  gpio_in,
  output logic      [GPE_NPORT-1:0][GPE_W-1:0]  gpio_out,
  output logic      [GPE_NPORT-1:0][GPE_W-1:0]  gpio_oe,
  output logic                                  irq,
  output logic                                  wake
);

  // ****************************************
  // State.
  // ****************************************
  logic [GPE_NPORT-1:0][GPE_W-1:0] dir;        // One drives the pin.
  logic [GPE_NPORT-1:0][GPE_W-1:0] mask;       // One hides the bit.
  logic [GPE_NPORT-1:0][GPE_W-1:0] outq;       // Output latch.
  logic [GPE_NPORT-1:0][GPE_W-1:0] pin_q;      // Sampled pin levels.
  logic [GPE_NEDGE-1:0][GPE_W-1:0] rise;       // Rising edge enables.
  logic [GPE_NEDGE-1:0][GPE_W-1:0] fall;       // Falling edge enables.
  logic [GPE_NEDGE-1:0][GPE_W-1:0] stat;       // Sticky edge status.
  logic [GPE_NEDGE-1:0][GPE_W-1:0] ien;        // Interrupt mask.
  logic [GPE_NPORT-1:0][GPE_W-1:0] next_dir;
  logic [GPE_NPORT-1:0][GPE_W-1:0] next_mask;
  logic [GPE_NPORT-1:0][GPE_W-1:0] next_outq;
  logic [GPE_NEDGE-1:0][GPE_W-1:0] next_rise;
  logic [GPE_NEDGE-1:0][GPE_W-1:0] next_fall;
  logic [GPE_NEDGE-1:0][GPE_W-1:0] next_stat;
  logic [GPE_NEDGE-1:0][GPE_W-1:0] next_ien;
  logic                            next_irq;
  logic [GPE_W-1:0]                next_prdata;
  logic                            next_pready;
  logic                            next_pslverr;

  gpe_dec_t         dec;     // Decoded address of the current transfer.
  logic [GPE_W-1:0] lm;      // Byte lanes written.
  logic             wr;      // Write commits this edge.
  logic             setup;   // Setup cycle of any transfer.

  gpe_edge_if #(.N(GPE_NEB)) eif ();

  // ****************************************
  // Edge capture and synchroniser.
  // ****************************************
  for (genvar k = 0; k < GPE_NEDGE; k++) begin : g_edge
    // Only ports 0 and 2 are wired to the capture flops.
    assign eif.pins[k*GPE_W +: GPE_W]    = gpio_in[GPE_EDGE_MAP[k]];
    assign eif.rise_en[k*GPE_W +: GPE_W] = rise[k];
    assign eif.fall_en[k*GPE_W +: GPE_W] = fall[k];
  end

  gpe_edge_cap u_cap (
    .e (eif.cap)
  );

  gpe_edge_sync u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .e       (eif.syn)
  );

  // Wake must work with the clock stopped, so it is taken straight from
  // the capture flops rather than through a clocked register.
  assign wake = |eif.capt;

  // ****************************************
  // Bus decode.
  // ****************************************
  // Every bus master, the processor or the DMA, sees the same slave.
  always_comb begin
    dec   = gpe_decode(paddr);
    lm    = gpe_lanes(pstrb);
    setup = psel & ~penable;
    wr    = psel & penable & pready & pwrite & ~pslverr;
  end

  // ****************************************
  // Register next values.
  // ****************************************
  always_comb begin
    next_dir  = dir;
    next_mask = mask;
    next_outq = outq;
    next_rise = rise;
    next_fall = fall;
    next_ien  = ien;
    for (int p = 0; p < GPE_NPORT; p++) begin
      if (wr && int'(dec.idx) == p) begin
        unique case (dec.kind)
          GPE_R_DIR:  next_dir[p]  = gpe_merge(dir[p], pwdata, lm);
          GPE_R_MASK: next_mask[p] = gpe_merge(mask[p], pwdata, lm);
          // Written lanes of the latch in one access; masked bits keep their value.
          GPE_R_PIN:  next_outq[p] = gpe_merge(outq[p], pwdata, lm & ~mask[p]);
          GPE_R_SET:  next_outq[p] = outq[p] | (pwdata & lm & ~mask[p]);
          GPE_R_CLR:  next_outq[p] = outq[p] & ~(pwdata & lm & ~mask[p]);
          default:    next_outq[p] = outq[p];
        endcase
      end
    end
    for (int k = 0; k < GPE_NEDGE; k++) begin
      // A new edge wins over a clear written in the same cycle.
      next_stat[k] = stat[k] | eif.evt[k*GPE_W +: GPE_W];
      if (wr && int'(dec.idx) == k) begin
        unique case (dec.kind)
          GPE_R_RISE: next_rise[k] = gpe_merge(rise[k], pwdata, lm);
          GPE_R_FALL: next_fall[k] = gpe_merge(fall[k], pwdata, lm);
          GPE_R_STAT: next_stat[k] = (stat[k] & ~(pwdata & lm))
                                     | eif.evt[k*GPE_W +: GPE_W];
          GPE_R_IEN:  next_ien[k]  = gpe_merge(ien[k], pwdata, lm);
          default:    next_ien[k]  = ien[k];
        endcase
      end
    end
    next_irq = |(next_stat & next_ien);
  end

  // ****************************************
  // Bus answer.
  // ****************************************
  // Data is prepared in the setup cycle so pready comes from a flop and
  // the access phase never adds a wait cycle.
  always_comb begin
    next_pready  = setup;
    next_pslverr = setup && dec.kind == GPE_R_NONE;
    next_prdata  = prdata;
    if (setup) begin
      unique case (dec.kind)
        GPE_R_DIR:  next_prdata = dir[dec.idx];
        GPE_R_MASK: next_prdata = mask[dec.idx];
        GPE_R_PIN:  next_prdata = pin_q[dec.idx] & ~mask[dec.idx];
        GPE_R_SET:  next_prdata = outq[dec.idx] & ~mask[dec.idx];
        GPE_R_RISE: next_prdata = rise[dec.idx];
        GPE_R_FALL: next_prdata = fall[dec.idx];
        GPE_R_STAT: next_prdata = stat[dec.idx];
        GPE_R_IEN:  next_prdata = ien[dec.idx];
        default:    next_prdata = GPE_ZERO;
      endcase
    end
  end

  // ****************************************
  // Registers.
  // ****************************************
  // All pins come out of reset as inputs with the latch cleared.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dir     <= '0;
      mask    <= '0;
      outq    <= '0;
      pin_q   <= '0;
      rise    <= '0;
      fall    <= '0;
      stat    <= '0;
      ien     <= '0;
      irq     <= 1'b0;
      prdata  <= GPE_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      dir     <= next_dir;
      mask    <= next_mask;
      outq    <= next_outq;
      pin_q   <= gpio_in;
      rise    <= next_rise;
      fall    <= next_fall;
      stat    <= next_stat;
      ien     <= next_ien;
      irq     <= next_irq;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Pins are driven straight from the latch and the direction flops.
  assign gpio_out = outq;
  assign gpio_oe  = dir;

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_dir_write;
    wr && dec.kind == GPE_R_DIR && dec.idx == 2'd1 && pstrb == '1
      |=> gpio_oe[1] == $past(pwdata);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_set_only;
    wr && dec.kind == GPE_R_SET && dec.idx == 2'd1
      |=> gpio_out[1] == ($past(outq[1]) | ($past(pwdata) & $past(lm) & ~$past(mask[1])));
  endproperty
  a_set_only: assert property (p_set_only) else $error("set write wrong");

  property p_clr_only;
    wr && dec.kind == GPE_R_CLR && dec.idx == 2'd1
      |=> (gpio_out[1] & $past(outq[1])) == gpio_out[1];
  endproperty
  a_clr_only: assert property (p_clr_only) else $error("clear write set a bit");

  property p_pin_read;
    setup && !pwrite && dec.kind == GPE_R_PIN && dec.idx == 2'd1
      |=> pready && prdata == ($past(pin_q[1]) & ~$past(mask[1]));
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

  property p_mask_keep;
    wr && dec.kind == GPE_R_PIN && dec.idx == 2'd1
      |=> (gpio_out[1] & mask[1]) == ($past(outq[1]) & mask[1]);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("masked bit changed");

  property p_lane_keep;
    wr && dec.kind == GPE_R_PIN && dec.idx == 2'd1 && !pstrb[0]
      |=> gpio_out[1][GPE_LANE_W-1:0] == $past(outq[1][GPE_LANE_W-1:0]);
  endproperty
  a_lane_keep: assert property (p_lane_keep) else $error("unwritten lane changed");

  property p_stat_sticky;
    !(wr && dec.kind == GPE_R_STAT) |=> (stat & $past(stat)) == $past(stat);
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status lost");

  property p_irq_level;
    ##1 irq == |(stat & ien);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_answer;
    setup |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing wrong");

  c_set: cover property (wr && dec.kind == GPE_R_SET);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
  c_wake: cover property ($rose(wake));

endmodule
`default_nettype wire

// ==== dv/gpe_pins.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Board side of the port pins.
// ****************************************
// A pin that the port drives shows the latch value. Any other pin shows the
// level that the board puts on it. There are no pulls here, so the bench
// always commands a definite board level.
module gpe_pins
  import gpe_pkg::*;
(
  input  wire logic [GPE_NPORT-1:0][GPE_W-1:0] gpio_out,
  input  wire logic [GPE_NPORT-1:0][GPE_W-1:0] gpio_oe,
  input  wire logic [GPE_NPORT-1:0][GPE_W-1:0] board_lvl,
  output logic      [GPE_NPORT-1:0][GPE_W-1:0] gpio_in
);
  // Each bit resolves on its own, so bit n of a port is pin n.
  always_comb begin
    gpio_in = (gpio_out & gpio_oe) | (board_lvl & ~gpio_oe);
  end
endmodule
`default_nettype wire

// ==== dv/gpe_port_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module gpe_port_bench
  import gpe_pkg::*;
();
  // ****************************************
  // Signals.
  // ****************************************
  logic                            clk_sys;    // System clock.
  logic                            clk_en;     // Low stops the clock.
  logic                            rst;        // Active high reset.
  logic [GPE_AW-1:0]               paddr;      // Bus address.
  logic                            psel;       // Bus select.
  logic                            penable;    // Bus access phase.
  logic                            pwrite;     // Bus direction.
  logic [GPE_W-1:0]                pwdata;     // Bus write data.
  logic [GPE_NLANE-1:0]            pstrb;      // Bus byte strobes.
  logic [GPE_W-1:0]                prdata;     // Bus read data.
  logic                            pready;     // Bus answer.
  logic                            pslverr;    // Bus error.
  logic [GPE_NPORT-1:0][GPE_W-1:0] gpio_in;    // Pin levels seen by the port.
  logic [GPE_NPORT-1:0][GPE_W-1:0] gpio_out;   // Output latch.
  logic [GPE_NPORT-1:0][GPE_W-1:0] gpio_oe;    // Output enables.
  logic [GPE_NPORT-1:0][GPE_W-1:0] board_lvl;  // Levels the board drives.
  logic                            irq;        // Interrupt level.
  logic                            wake;       // Clockless wake request.
  logic                            wake_seen;  // Set by any rise of wake.
  logic [GPE_W-1:0]                rdv;        // Last read data taken.
  logic                            errv;       // Last error taken.
  int                              bad_count;  // Mismatches.
  int                              n_compared; // Comparisons made.

  gpe_port DUT (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq(irq), .wake(wake));

  gpe_pins u_pins (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .board_lvl(board_lvl),
    .gpio_in(gpio_in));

  // ****************************************
  // Clock, watchdog and wake monitor.
  // ****************************************
  // The clock can be held still to show that edges are caught without it.
  initial begin
    clk_sys = 1'b0;
    forever begin
      #2;
      if (clk_en) begin
        clk_sys = ~clk_sys;
      end
    end
  end

  // The tests take about 600 nanoseconds; this is a wide margin.
  initial begin
    #20000;
    bad_count++;
    summarize();
  end

  // Wake is asynchronous, so it is caught by its own edge, not sampled.
  always @(posedge wake) begin
    wake_seen = 1'b1;
  end

  // ****************************************
  // Bus tasks.
  // ****************************************
  function automatic logic [GPE_AW-1:0] pa(input int p, input logic [4:0] o);
    return GPE_AW'(p * 32) | GPE_AW'(o);
  endfunction

  function automatic logic [GPE_AW-1:0] ea(input int k, input logic [4:0] o);
    return GPE_AW'(12'h080 + k * 32) | GPE_AW'(o);
  endfunction

  // One transfer; it waits for pready as long as it takes, since only the
  // watchdog ends a hang, then idles one cycle so that select never changes
  // twice in one time step.
  task automatic apb(input logic w, input logic [GPE_AW-1:0] a,
                     input logic [GPE_W-1:0] d, input logic [GPE_NLANE-1:0] s);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [GPE_AW-1:0] a, input logic [GPE_W-1:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  // A read also expects no error.
  task automatic rd(input logic [GPE_AW-1:0] a, input logic [GPE_W-1:0] exp);
    apb(1'b0, a, GPE_ZERO, 4'h0);
    `CHK({errv, rdv}, {1'b0, exp})
  endtask

  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests.
  // ****************************************
  initial begin
    clk_en = 1'b1; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pstrb = '0; board_lvl = '0; wake_seen = 1'b0;
    bad_count = 0; n_compared = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK({irq, gpio_oe, gpio_out}, '0)
    rd(pa(2, GPE_OFS_DIR), GPE_ZERO);
    // Direction and a whole-word write on port 1.
    board_lvl[1] <= 32'hA5A5_A5A5;
    wr(pa(1, GPE_OFS_DIR), 32'h0000_FF0F);
    `CHK(gpio_oe, {GPE_ZERO, 32'h0000_FF0F, GPE_ZERO})
    wr(pa(1, GPE_OFS_PIN), 32'h1234_5678);
    `CHK(gpio_out[1], 32'h1234_5678)
    rd(pa(1, GPE_OFS_SET), 32'h1234_5678);
    rd(pa(1, GPE_OFS_PIN), 32'hA5A5_56A8);
    // Set and clear touch only the ones written.
    wr(pa(1, GPE_OFS_SET), 32'h8000_0081);
    `CHK(gpio_out[1], 32'h9234_56F9)
    wr(pa(1, GPE_OFS_CLR), 32'h0000_0078);
    `CHK(gpio_out[1], 32'h9234_5681)
    // Narrow writes change only their lanes.
    apb(1'b1, pa(1, GPE_OFS_PIN), 32'hFFFF_FFFF, 4'b0010);
    `CHK(gpio_out[1], 32'h9234_FF81)
    apb(1'b1, pa(1, GPE_OFS_SET), 32'h00FF_0000, 4'b1100);
    `CHK(gpio_out[1], 32'h92FF_FF81)
    // Masked bits keep their value and read as zero.
    wr(pa(1, GPE_OFS_MASK), 32'hFFFF_0000);
    wr(pa(1, GPE_OFS_PIN), GPE_ZERO);
    `CHK(gpio_out[1], 32'h92FF_0000)
    wr(pa(1, GPE_OFS_SET), 32'hFFFF_FFFF);
    rd(pa(1, GPE_OFS_SET), 32'h0000_FFFF);
    wr(pa(1, GPE_OFS_MASK), GPE_ZERO);
    // Unmapped places answer with an error and change nothing.
    apb(1'b0, 12'h060, GPE_ZERO, 4'h0);
    `CHK({errv, rdv}, {1'b1, GPE_ZERO})
    apb(1'b1, 12'h014, 32'hFFFF_FFFF, 4'hF);
    `CHK({errv, gpio_out[1]}, {1'b1, 32'h92FF_FFFF})
    // Port 0 pin 5 on both edges, passed to the interrupt.
    wr(ea(0, GPE_OFS_RISE), 32'h0000_0020);
    wr(ea(0, GPE_OFS_FALL), 32'h0000_0020);
    wr(ea(0, GPE_OFS_IEN), 32'h0000_0020);
    board_lvl[0][5] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(ea(0, GPE_OFS_STAT), 32'h0000_0020);
    `CHK({irq, wake_seen}, 2'b11)
    wr(ea(0, GPE_OFS_STAT), 32'h0000_0020);
    rd(ea(0, GPE_OFS_STAT), GPE_ZERO);
    `CHK(irq, 1'b0)
    board_lvl[0][5] <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(ea(0, GPE_OFS_STAT), 32'h0000_0020);
    wr(ea(0, GPE_OFS_STAT), 32'h0000_0020);
    // Port 2 pin 31 on rising edges only, first with the interrupt masked.
    wr(ea(1, GPE_OFS_RISE), 32'h8000_0000);
    board_lvl[2][31] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(ea(1, GPE_OFS_STAT), 32'h8000_0000);
    `CHK(irq, 1'b0)
    wr(ea(1, GPE_OFS_IEN), 32'h8000_0000);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    wr(ea(1, GPE_OFS_STAT), 32'h8000_0000);
    board_lvl[2][31] <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(ea(1, GPE_OFS_STAT), GPE_ZERO);
    // With the clock stopped an edge still raises wake and is kept.
    wake_seen = 1'b0;
    clk_en = 1'b0;
    #20;
    board_lvl[0][5] <= 1'b1;
    #20;
    `CHK({wake, wake_seen}, 2'b11)
    clk_en = 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(ea(0, GPE_OFS_STAT), 32'h0000_0020);
    summarize();
  end
endmodule
`default_nettype wire
